//--- mcbr_pkg.sv
// Package of constants and types for the monitor and control bus responder.
package mcbr_pkg;

	// ==========================================
	// Timing
	// ==========================================
	localparam int CLK_HZ              = 40_000_000;
	localparam int BAUD_RATE           = 57_600;
	localparam int BIT_CYCLES          = CLK_HZ / BAUD_RATE;
	localparam int ACK_LIMIT_US        = 382;
	localparam int CYCLES_PER_US       = CLK_HZ / 1_000_000;
	localparam int ACK_LIMIT_CYCLES    = (ACK_LIMIT_US * CYCLES_PER_US);
	localparam int SECOND_LIMIT_US     = 573;
	localparam int SECOND_LIMIT_CYCLES = (SECOND_LIMIT_US * CYCLES_PER_US);
	localparam int HANDSHAKE_CYCLES    = 4000;

	// ==========================================
	// Function codes
	// ==========================================
	localparam logic [7:0] MESSAGE_SYNC_CODE = 8'h16;
	localparam logic [7:0] ACK_CODE          = 8'h06;
	localparam logic [7:0] SECOND_ACK_CODE   = 8'h11;
	localparam logic [7:0] NAK_CODE          = 8'h15;
	localparam logic [7:0] NO_RESPONSE_CODE  = 8'h12;

	// ==========================================
	// Address block
	// ==========================================
	localparam logic [14:0] BLOCK_START_RESET = 15'h0000;
	localparam logic [14:0] BLOCK_SIZE        = 15'h0220;
	localparam int          INTERNAL_COUNT    = 16;
	localparam logic [15:0] IFACE_TYPE_CODE   = 16'h0101; // Arbitrary value.
	localparam logic [15:0] COUNTER_RESET     = 16'h0000;

	// Internal slots, counted down from the block end address.
	localparam logic [3:0] SLOT_NO_CTRL_RESP = 4'hC;
	localparam logic [3:0] SLOT_NO_MON_RESP  = 4'hB;
	localparam logic [3:0] SLOT_IFACE_TYPE   = 4'hA;
	localparam logic [3:0] SLOT_LAST_ADDR    = 4'h9;
	localparam logic [3:0] SLOT_LAST_ARG     = 4'h8;
	localparam logic [3:0] SLOT_ADDR_PAR     = 4'h7;
	localparam logic [3:0] SLOT_ARG_PAR_ALL  = 4'h6;
	localparam logic [3:0] SLOT_BAD_SYNC     = 4'h5;
	localparam logic [3:0] SLOT_ARG_PAR_BLK  = 4'h4;
	localparam logic [3:0] SLOT_BLOCK_ID     = 4'h3;
	localparam logic [3:0] SLOT_CTRL_COUNT   = 4'h2;
	localparam logic [3:0] SLOT_MON_COUNT    = 4'h1;
	localparam logic [3:0] SLOT_BLOCK_START  = 4'h0;

	// ==========================================
	// Types
	// ==========================================
	typedef struct packed {
		logic [7:0] data;
		logic       parity_odd;
	} mcbr_char_s;

	typedef struct packed {
		logic        is_control;
		logic [14:0] address;
		logic [15:0] argument;
	} mcbr_request_s;

endpackage

//--- mcbr_fifo.sv
// Reply character FIFO with parameterised width and depth.
module mcbr_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             reset_n,
	// Fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_q;
	logic [AW-1:0]    rd_q;
	logic [AW:0]      cnt_q;
	wire              push = in_valid && in_ready;
	wire              pop  = out_valid && out_ready;

	assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
	assign out_valid = (cnt_q != '0);
	assign out_data  = mem[rd_q];

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_q] <= in_data;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
			end
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

//--- mcbr_responder.sv
// Monitor and control bus responder: receiver, decoder, counters and reply sender.
module mcbr_responder
	import mcbr_pkg::*;
#(
	parameter int HANDSHAKE_LIMIT = HANDSHAKE_CYCLES,
	parameter int FIFO_DEPTH      = 8
) (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        reset_n,
	// Bus lines
	input  wire logic        command_line,
	output logic             reply_line_o,
	output logic             reply_line_oe,
	// Device identification and block table
	input  wire logic [7:0]  device_id,
	output logic [7:0]       table_index,
	input  wire logic [14:0] table_block_start,
	// Device handshake
	output logic             dev_request,
	output logic             dev_is_control,
	output logic [14:0]      dev_channel,
	output logic [15:0]      dev_argument,
	input  wire logic        dev_ack,
	input  wire logic [15:0] dev_monitor_data
);
	// ==========================================
	// Receiver
	// ==========================================
	typedef enum logic [1:0] {RX_IDLE, RX_BITS, RX_STOP} mcbr_rx_e;
	mcbr_rx_e    rx_state_q;
	logic [15:0] rx_cnt_q;
	logic [3:0]  rx_bit_q;
	logic [8:0]  rx_sh_q;
	logic        rx_done_q;
	mcbr_char_s  rx_char_q;
	wire         rx_bit_tick = (rx_cnt_q == 16'd0);

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rx_state_q <= RX_IDLE;
			rx_cnt_q   <= '0;
			rx_bit_q   <= '0;
			rx_sh_q    <= '0;
			rx_done_q  <= 1'b0;
			rx_char_q  <= '0;
		end else begin
			rx_done_q <= 1'b0;
			if (rx_cnt_q != 16'd0) rx_cnt_q <= rx_cnt_q - 1'b1;
			unique case (rx_state_q)
				RX_IDLE: if (!command_line) begin
					rx_cnt_q   <= 16'(BIT_CYCLES + BIT_CYCLES / 2);
					rx_bit_q   <= '0;
					rx_state_q <= RX_BITS;
				end
				RX_BITS: if (rx_bit_tick) begin
					rx_sh_q  <= {command_line, rx_sh_q[8:1]};
					rx_cnt_q <= 16'(BIT_CYCLES);
					rx_bit_q <= rx_bit_q + 1'b1;
					if (rx_bit_q == 4'd8) rx_state_q <= RX_STOP;
				end
				RX_STOP: if (rx_bit_tick) begin
					rx_state_q <= RX_IDLE;
					rx_done_q  <= command_line;
					rx_char_q  <= '{data: rx_sh_q[7:0], parity_odd: ^rx_sh_q};
				end
			endcase
		end
	end

	// ==========================================
	// Message decode
	// ==========================================
	logic [2:0]    byte_idx_q;
	logic          hunting_q;
	logic          arg_bad_q;
	mcbr_request_s req_q;
	logic [14:0]   block_start_q;

	wire is_sync_char = !rx_char_q.parity_odd;
	wire bad_sync     = is_sync_char && rx_char_q.data != MESSAGE_SYNC_CODE;
	wire good_sync    = is_sync_char && !bad_sync;
	wire [14:0] rx_address   = {req_q.address[14:8], rx_char_q.data} ;
	wire [14:0] block_end    = block_start_q + BLOCK_SIZE - 15'd1;
	wire        in_block     = rx_address >= block_start_q && rx_address <= block_end;
	wire        internal_hit = (block_end - req_q.address) < 15'(INTERNAL_COUNT);
	wire [3:0]  slot         = 4'(block_end - req_q.address);

	// ==========================================
	// Reply sequencer
	// ==========================================
	typedef enum logic [2:0] {SQ_IDLE, SQ_ACK, SQ_WAIT_ARG, SQ_DEVICE, SQ_HOLD, SQ_SECOND}
		mcbr_seq_e;
	mcbr_seq_e   seq_q;
	logic [15:0] wait_q;
	logic [15:0] min_q;
	logic [15:0] hs_q;
	logic [7:0]  second_q;
	logic        mono_q;
	logic [15:0] mon_q;
	logic        fifo_in_valid;
	logic        fifo_in_ready;
	mcbr_char_s  fifo_in_data;

	logic [15:0] cnt_q [INTERNAL_COUNT];

	wire addr_low_done = rx_done_q && byte_idx_q == 3'd2 && !hunting_q;
	wire arg_low_done  = rx_done_q && byte_idx_q == 3'd4 && !hunting_q;
	wire addr_good     = addr_low_done && rx_char_q.parity_odd && !arg_bad_q;

	// Internal reads return counters; fixed slots read the type code, device_id and block start.
	wire [15:0] internal_value =
		(slot == SLOT_IFACE_TYPE)  ? IFACE_TYPE_CODE :
		(slot == SLOT_BLOCK_ID)    ? {8'h00, device_id} :
		(slot == SLOT_BLOCK_START) ? {1'b0, block_start_q} : cnt_q[slot];

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			byte_idx_q    <= '0;
			hunting_q     <= 1'b1;
			arg_bad_q     <= 1'b0;
			req_q         <= '0;
			block_start_q <= BLOCK_START_RESET;
			seq_q         <= SQ_IDLE;
			wait_q        <= '0;
			min_q         <= '0;
			hs_q          <= '0;
			second_q      <= '0;
			mono_q        <= 1'b0;
			mon_q         <= '0;
			dev_request   <= 1'b0;
			dev_is_control <= 1'b0;
			dev_channel   <= '0;
			dev_argument  <= '0;
			table_index   <= '0;
			for (int i = 0; i < INTERNAL_COUNT; i++) cnt_q[i] <= COUNTER_RESET;
		end else begin
			block_start_q <= table_block_start;
			table_index   <= device_id;
			if (min_q != 16'd0) min_q <= min_q - 1'b1;
			if (rx_done_q) begin
				if (good_sync) begin
					byte_idx_q <= 3'd1;
					hunting_q  <= 1'b0;
					arg_bad_q  <= 1'b0;
				end else if (!hunting_q) begin
					// Inside a message every other byte fills its slot, so parity errors are seen.
					byte_idx_q <= byte_idx_q + 1'b1;
					unique case (byte_idx_q)
						3'd1: begin
							req_q.is_control   <= rx_char_q.data[7];
							req_q.address[14:8] <= rx_char_q.data[6:0];
							arg_bad_q          <= !rx_char_q.parity_odd;
						end
						3'd2: begin
							req_q.address[7:0] <= rx_char_q.data;
							if (arg_bad_q || !rx_char_q.parity_odd) begin
								cnt_q[SLOT_ADDR_PAR] <= cnt_q[SLOT_ADDR_PAR] + 1'b1;
								hunting_q <= 1'b1;
							end
							arg_bad_q <= 1'b0;
						end
						3'd3: begin
							req_q.argument[15:8] <= rx_char_q.data;
							arg_bad_q <= !rx_char_q.parity_odd;
						end
						3'd4: begin
							req_q.argument[7:0] <= rx_char_q.data;
							hunting_q <= 1'b1;
							if (arg_bad_q || !rx_char_q.parity_odd) begin
								cnt_q[SLOT_ARG_PAR_ALL] <= cnt_q[SLOT_ARG_PAR_ALL] + 1'b1;
								arg_bad_q <= 1'b1;
							end
						end
						default: hunting_q <= 1'b1;
					endcase
				end else if (bad_sync) begin
					cnt_q[SLOT_BAD_SYNC] <= cnt_q[SLOT_BAD_SYNC] + 1'b1;
				end
			end
			unique case (seq_q)
				SQ_IDLE: if (addr_good && in_block) begin
					mono_q <= !req_q.is_control;
					seq_q  <= SQ_ACK;
					min_q  <= 16'(SECOND_LIMIT_CYCLES - 11 * BIT_CYCLES);
				end
				SQ_ACK: if (fifo_in_ready) begin
					seq_q <= mono_q ? SQ_DEVICE : SQ_WAIT_ARG;
					hs_q  <= 16'(HANDSHAKE_LIMIT);
					if (mono_q) begin
						dev_request    <= !internal_hit;
						dev_is_control <= 1'b0;
						dev_channel    <= req_q.address;
					end
				end
				SQ_WAIT_ARG: if (arg_low_done) begin
					if (arg_bad_q || !rx_char_q.parity_odd) begin
						second_q <= NAK_CODE;
						cnt_q[SLOT_ARG_PAR_BLK] <= cnt_q[SLOT_ARG_PAR_BLK] + 1'b1;
						seq_q    <= SQ_HOLD;
					end else if (internal_hit) begin
						if (slot != SLOT_IFACE_TYPE && slot != SLOT_BLOCK_ID &&
							slot != SLOT_BLOCK_START) begin
							cnt_q[slot] <= {req_q.argument[15:8], rx_char_q.data};
						end
						second_q <= SECOND_ACK_CODE;
						seq_q    <= SQ_HOLD;
					end else begin
						dev_request    <= 1'b1;
						dev_is_control <= 1'b1;
						dev_channel    <= req_q.address;
						dev_argument   <= {req_q.argument[15:8], rx_char_q.data};
						cnt_q[SLOT_LAST_ADDR] <= {1'b1, req_q.address};
						cnt_q[SLOT_LAST_ARG]  <= {req_q.argument[15:8], rx_char_q.data};
						seq_q <= SQ_DEVICE;
					end
				end
				SQ_DEVICE: begin
					hs_q <= hs_q - 1'b1;
					if (!dev_request && mono_q) begin
						mon_q    <= internal_value;
						second_q <= 8'h00;
						seq_q    <= SQ_HOLD;
					end else if (dev_ack) begin
						dev_request <= 1'b0;
						mon_q       <= dev_monitor_data;
						second_q    <= mono_q ? 8'h00 : SECOND_ACK_CODE;
						if (mono_q) cnt_q[SLOT_MON_COUNT] <= cnt_q[SLOT_MON_COUNT] + 1'b1;
						else cnt_q[SLOT_CTRL_COUNT] <= cnt_q[SLOT_CTRL_COUNT] + 1'b1;
						seq_q <= SQ_HOLD;
					end else if (hs_q == 16'd0) begin
						dev_request <= 1'b0;
						second_q    <= NO_RESPONSE_CODE;
						if (mono_q) cnt_q[SLOT_NO_MON_RESP] <= cnt_q[SLOT_NO_MON_RESP] + 1'b1;
						else cnt_q[SLOT_NO_CTRL_RESP] <= cnt_q[SLOT_NO_CTRL_RESP] + 1'b1;
						seq_q <= SQ_HOLD;
					end
				end
				SQ_HOLD: if (min_q == 16'd0 || mono_q) begin
					seq_q  <= SQ_SECOND;
					wait_q <= 16'd2;
				end
				SQ_SECOND: if (fifo_in_ready) begin
					if (mono_q && second_q == 8'h00) begin
						if (wait_q == 16'd2) wait_q <= 16'd1;
						else seq_q <= SQ_IDLE;
					end else begin
						seq_q <= SQ_IDLE;
					end
					if (mono_q && second_q == 8'h00 && wait_q != 16'd2) seq_q <= SQ_IDLE;
				end
			endcase
		end
	end

	// Characters queued for the sender.
	always_comb begin
		fifo_in_valid = 1'b0;
		fifo_in_data  = '{data: 8'h00, parity_odd: 1'b0};
		if (seq_q == SQ_ACK) begin
			fifo_in_valid = 1'b1;
			fifo_in_data  = '{data: ACK_CODE, parity_odd: 1'b0};
		end else if (seq_q == SQ_SECOND) begin
			fifo_in_valid = 1'b1;
			if (!(mono_q && second_q == 8'h00)) begin
				fifo_in_data = '{data: second_q, parity_odd: 1'b0};
			end else if (wait_q == 16'd2) begin
				fifo_in_data = '{data: mon_q[15:8], parity_odd: 1'b1};
			end else begin
				fifo_in_data = '{data: mon_q[7:0], parity_odd: 1'b1};
			end
		end
	end

	// ==========================================
	// Transmitter
	// ==========================================
	logic        tx_valid;
	logic        tx_ready;
	mcbr_char_s  tx_data;
	logic [10:0] tx_sh_q;
	logic [3:0]  tx_left_q;
	logic [15:0] tx_cnt_q;
	// The parity kind travels with each character, so data equal to a code keeps odd parity.
	wire         tx_par  = tx_data.parity_odd ? ~^tx_data.data : ^tx_data.data;

	assign tx_ready = (tx_left_q == 4'd0);

	mcbr_fifo #(.WIDTH($bits(mcbr_char_s)), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk       (clk),
		.reset_n   (reset_n),
		.in_valid  (fifo_in_valid),
		.in_ready  (fifo_in_ready),
		.in_data   (fifo_in_data),
		.out_valid (tx_valid),
		.out_ready (tx_ready),
		.out_data  (tx_data)
	);

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			tx_sh_q       <= '1;
			tx_left_q     <= '0;
			tx_cnt_q      <= '0;
			reply_line_o  <= 1'b1;
			reply_line_oe <= 1'b0;
		end else if (tx_left_q == 4'd0) begin
			reply_line_o  <= 1'b1;
			reply_line_oe <= 1'b0;
			if (tx_valid) begin
				tx_sh_q   <= {1'b1, tx_par, tx_data.data, 1'b0};
				tx_left_q <= 4'd11;
				tx_cnt_q  <= '0;
			end
		end else begin
			reply_line_oe <= 1'b1;
			reply_line_o  <= tx_sh_q[0];
			if (tx_cnt_q == 16'(BIT_CYCLES - 1)) begin
				tx_cnt_q  <= '0;
				tx_sh_q   <= {1'b1, tx_sh_q[10:1]};
				tx_left_q <= tx_left_q - 1'b1;
			end else begin
				tx_cnt_q <= tx_cnt_q + 1'b1;
			end
		end
	end
endmodule

//--- mcbr_responder_checker.sv
// Concurrent checks on the ports of the monitor and control bus responder.
module mcbr_responder_checker
	import mcbr_pkg::*;
#(
	parameter int HANDSHAKE_LIMIT = 4000
) (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        reset_n,
	// Reply line
	input  wire logic        reply_line_o,
	input  wire logic        reply_line_oe,
	// Device side
	input  wire logic [7:0]  device_id,
	input  wire logic [7:0]  table_index,
	input  wire logic        dev_request,
	input  wire logic        dev_ack,
	input  wire logic        dev_is_control,
	input  wire logic [14:0] dev_channel,
	input  wire logic [15:0] dev_argument
);
	// ==========================================
	// Helper counters
	// ==========================================
	logic [15:0] tx_cnt_q;
	logic [15:0] req_cnt_q;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			tx_cnt_q  <= 16'h0000;
			req_cnt_q <= 16'h0000;
		end else begin
			tx_cnt_q  <= reply_line_oe ? tx_cnt_q + 16'h0001 : 16'h0000;
			req_cnt_q <= dev_request ? req_cnt_q + 16'h0001 : 16'h0000;
		end
	end

	// ==========================================
	// Assertions
	// ==========================================
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	sequence start_low;
		!reply_line_o [*8];
	endsequence

	a_start_bit: assert property (
		$rose(reply_line_oe) |-> start_low
	) else $error("reply start bit missing");
	a_start_len: assert property (
		reply_line_oe && tx_cnt_q < 16'd694 |-> !reply_line_o
	) else $error("reply start bit too short");
	a_stop_high: assert property (
		reply_line_oe && tx_cnt_q inside {[16'd6940:16'd7633]} |-> reply_line_o
	) else $error("reply stop bit not high");
	a_full_char: assert property (
		$fell(reply_line_oe) |-> $past(tx_cnt_q) >= 16'd7633
	) else $error("reply line released inside a character");
	a_table_pass: assert property (
		$past(reset_n) |-> table_index == $past(device_id)
	) else $error("table index differs from device id");
	a_req_holds: assert property (
		dev_request && !dev_ack && req_cnt_q < HANDSHAKE_LIMIT - 2 |=> dev_request
	) else $error("device request dropped early");
	a_req_bound: assert property (
		dev_request |-> req_cnt_q <= HANDSHAKE_LIMIT
	) else $error("device request outlived its limit");
	a_req_stable: assert property (
		dev_request && $past(dev_request) |-> $stable({dev_is_control, dev_channel, dev_argument})
	) else $error("device request fields changed");
	a_ack_ends: assert property (
		dev_request && dev_ack |-> ##[1:4] !dev_request
	) else $error("device request kept after acknowledge");
endmodule

bind mcbr_responder mcbr_responder_checker #(
	.HANDSHAKE_LIMIT(HANDSHAKE_LIMIT)
) u_checker (
	.clk           (clk),
	.reset_n       (reset_n),
	.reply_line_o  (reply_line_o),
	.reply_line_oe (reply_line_oe),
	.device_id     (device_id),
	.table_index   (table_index),
	.dev_request   (dev_request),
	.dev_ack       (dev_ack),
	.dev_is_control(dev_is_control),
	.dev_channel   (dev_channel),
	.dev_argument  (dev_argument)
);

//--- mcbr_bus_controller.sv
// Behavioural bus controller: sends command characters and decodes reply characters.
module mcbr_bus_controller
	import mcbr_pkg::*;
(
	// Clock
	input  wire logic clk,
	// Bus lines
	output logic       command_line,
	input  wire logic  reply_line_o,
	input  wire logic  reply_line_oe,
	// Decoded replies
	output logic       rx_valid,
	output mcbr_char_s rx_char,
	output logic       rx_stop
);
	timeunit 1ns;
	timeprecision 1ps;

	logic       line_w;
	logic [9:0] bits;

	// A released reply line is biased to the idle mark level.
	assign line_w = reply_line_oe ? reply_line_o : 1'b1;

	// Sends one character, changing the line only on falling edges.
	task automatic send_char(input logic [7:0] d, input logic code, input logic bad);
		logic [10:0] frame;
		frame = {1'b1, (^d) ^ ~code ^ bad, d, 1'b0};
		for (int i = 0; i < 11; i++) begin
			command_line = frame[i];
			repeat (BIT_CYCLES) @(negedge clk);
		end
	endtask

	initial begin
		command_line = 1'b1;
		rx_valid = 1'b0;
		rx_char = '0;
		rx_stop = 1'b0;
		forever begin
			@(negedge line_w);
			repeat (BIT_CYCLES / 2) @(posedge clk);
			for (int i = 0; i < 10; i++) begin
				repeat (BIT_CYCLES) @(posedge clk);
				bits[i] = line_w;
			end
			rx_char = '{bits[7:0], ^bits[8:0]};
			rx_stop = bits[9];
			rx_valid = 1'b1;
			@(posedge clk);
			rx_valid = 1'b0;
		end
	end
endmodule

//--- mcbr_responder_tb.sv
// Self-checking testbench for the monitor and control bus responder.
module mcbr_responder_tb
	import mcbr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic        clk;
	logic        reset_n;
	logic        command_line;
	logic        reply_line_o;
	logic        reply_line_oe;
	logic [7:0]  device_id;
	logic [7:0]  table_index;
	logic [14:0] table_block_start;
	logic        dev_request;
	logic        dev_is_control;
	logic [14:0] dev_channel;
	logic [15:0] dev_argument;
	logic        dev_ack;
	logic [15:0] dev_monitor_data;
	logic        rx_valid;
	logic        rx_stop;
	mcbr_char_s  rx_char;
	mcbr_char_s  exp_q[$];
	integer      seed;
	integer      errors;
	integer      cmp_count;
	integer      cycles;
	integer      ack_wait;
	logic [15:0] ctl_arg;
	logic [15:0] exp_addr;
	event        adl_done;

	initial clk = 1'b0;
	always #12.5 clk = ~clk;

	mcbr_responder #(
		.HANDSHAKE_LIMIT(HANDSHAKE_CYCLES),
		.FIFO_DEPTH     (8)
	) dut (
		.clk              (clk),
		.reset_n          (reset_n),
		.command_line     (command_line),
		.reply_line_o     (reply_line_o),
		.reply_line_oe    (reply_line_oe),
		.device_id        (device_id),
		.table_index      (table_index),
		.table_block_start(table_block_start),
		.dev_request      (dev_request),
		.dev_is_control   (dev_is_control),
		.dev_channel      (dev_channel),
		.dev_argument     (dev_argument),
		.dev_ack          (dev_ack),
		.dev_monitor_data (dev_monitor_data)
	);

	mcbr_bus_controller ctl (
		.clk          (clk),
		.command_line (command_line),
		.reply_line_o (reply_line_o),
		.reply_line_oe(reply_line_oe),
		.rx_valid     (rx_valid),
		.rx_char      (rx_char),
		.rx_stop      (rx_stop)
	);

	// ==========================================
	// Tasks
	// ==========================================
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic note(input logic [7:0] d, input logic odd);
		exp_q.push_back('{d, odd});
	endtask

	task automatic send_msg(input logic [15:0] addr, input logic [15:0] arg, input logic bad);
		exp_addr = addr;
		ctl.send_char(MESSAGE_SYNC_CODE, 1'b1, 1'b0);
		ctl.send_char(addr[15:8], 1'b0, 1'b0);
		ctl.send_char(addr[7:0], 1'b0, 1'b0);
		->adl_done;
		ctl.send_char(arg[15:8], 1'b0, bad);
		ctl.send_char(arg[7:0], 1'b0, 1'b0);
	endtask

	// ==========================================
	// Device, reply and timing watchers
	// ==========================================
	always @(negedge clk) begin
		if (dev_request === 1'b1 && dev_ack === 1'b0) begin
			if (dev_is_control === 1'b1) check(dev_argument, ctl_arg);
			check({dev_is_control, dev_channel}, exp_addr);
			dev_ack <= 1'b1;
		end else if (dev_request !== 1'b1) begin
			dev_ack <= 1'b0;
		end
	end

	always @(negedge clk) begin
		if (rx_valid === 1'b1) begin
			if (exp_q.size() == 0) check({7'h00, rx_char}, 16'hFFFF);
			else check({7'h00, rx_char}, {7'h00, exp_q.pop_front()});
			check({15'h0000, rx_stop}, 16'h0001);
		end
	end

	always begin
		@(adl_done);
		ack_wait = 0;
		while (reply_line_oe !== 1'b1 && ack_wait <= ACK_LIMIT_CYCLES) begin
			@(negedge clk);
			ack_wait++;
		end
		check({15'h0000, ack_wait <= ACK_LIMIT_CYCLES}, 16'h0001);
	end

	always @(posedge clk) begin
		cycles = cycles + 1;
		if (cycles == 90000) begin
			errors++;
			close_out();
		end
	end

	// ==========================================
	// Main sequence
	// ==========================================
	initial begin
		seed = 32'h4DCC2E7B;
		errors = 0;
		cmp_count = 0;
		cycles = 0;
		reset_n = 1'b0;
		dev_ack = 1'b0;
		exp_addr = 16'h0000;
		device_id = 8'($random(seed));
		table_block_start = 15'h0100;
		dev_monitor_data = 16'($random(seed));
		ctl_arg = 16'($random(seed));
		repeat (5) @(negedge clk);
		reset_n = 1'b1;
		@(negedge clk);
		// Control message, followed at once by a monitor request.
		note(ACK_CODE, 1'b0);
		note(SECOND_ACK_CODE, 1'b0);
		send_msg(16'h8105, ctl_arg, 1'b0);
		// The monitor request carries a corrupted argument and still returns data.
		note(ACK_CODE, 1'b0);
		note(dev_monitor_data[15:8], 1'b1);
		note(dev_monitor_data[7:0], 1'b1);
		send_msg(16'h0107, 16'h0000, 1'b1);
		while (exp_q.size() != 0) @(negedge clk);
		repeat (BIT_CYCLES) @(negedge clk);
		check({15'h0000, reply_line_oe}, 16'h0000);
		close_out();
	end
endmodule
